// file: design/sr_cfg.svh
// Constants for the sleep/active resource controller: register map,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef SR_CFG_SVH
`define SR_CFG_SVH

// Register word offsets on the plain register port
`define SR_OFS_CTRL 6'h00
`define SR_OFS_POL 6'h01
`define SR_OFS_SLP_RES 6'h02
`define SR_OFS_SLP_SMPS 6'h03
`define SR_OFS_SLP_LDO 6'h04
`define SR_OFS_A_RES 6'h05
`define SR_OFS_A_SMPS 6'h06
`define SR_OFS_A_LDO 6'h07
`define SR_OFS_B_RES 6'h08
`define SR_OFS_B_SMPS 6'h09
`define SR_OFS_B_LDO 6'h0A
`define SR_OFS_SEQ_BASE 6'h0B
`define SR_OFS_SW_EN 6'h0C
`define SR_OFS_STATUS 6'h0D
`define SR_OFS_ACTIVE 6'h0E
`define SR_OFS_IN_SEQ 6'h0F
// Address bit that selects the sequence step memory
`define SR_MEM_SEL_BIT 5

// Field positions
`define SR_CTRL_START_BIT 0
`define SR_CTRL_SLP_UNMASK_BIT 1
`define SR_POL_SLEEP_BIT 0
`define SR_POL_A_BIT 1
`define SR_POL_B_BIT 2

// Reset values
`define SR_POL_RST 3'h0
`define SR_SEQ_BASE_RST 15'h0000

// Step delay unit and clock period, in ns
`define SR_STEP_UNIT_NS 10000
`define SR_CLK_PERIOD_NS 100
`define SR_STEP_CYCLES (`SR_STEP_UNIT_NS / `SR_CLK_PERIOD_NS)

`endif

// file: design/sr_pkg.sv
// Types shared by the sleep/active resource controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package sr_pkg;

  // Synchronised control pin levels
  typedef struct packed {
    logic sleep;
    logic ctl_a;
    logic ctl_b;
  } sr_pins_t;

  // One step of a stored power sequence
  typedef struct packed {
    logic last;
    logic on;
    logic [1:0] spare;
    logic [3:0] res;
    logic [7:0] delay;
  } sr_step_t;

  // Which sequence the engine runs
  typedef enum logic [1:0] {
    SR_SEQ_UP,
    SR_SEQ_A2S,
    SR_SEQ_S2A
  } sr_seq_kind_t;

  // Engine states
  typedef enum logic [2:0] {
    SR_ST_OFF,
    SR_ST_FETCH,
    SR_ST_EXEC,
    SR_ST_WAIT,
    SR_ST_ACTIVE,
    SR_ST_SLEEP
  } sr_state_t;

endpackage

// file: design/sr_step_mem.sv
// Small step memory for the power sequences.
// Assumes one write port from the register port and one read port
// from the sequence engine, both on the same clock.
`timescale 1ns/10ps
module sr_step_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5,
  parameter int DW = 16
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] nxt_rd_data;

  // Read data always come out of a register
  always_comb begin
    nxt_rd_data = mem[rd_addr];
  end

  // Storage and registered read
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= nxt_rd_data;
  end

endmodule

// file: design/sr_resource_ctl.sv
// Sleep and active mode control for regulators, clock and enable
// outputs, with the power sequence engine that walks stored steps.
// Assumes pins arrive asynchronously and registers are reached over a
// plain port with read data one cycle after the read strobe.
// Functional notes
// - Each of the three control pins has its own polarity setting.
// - By default a direct control pin requests active when it goes high.
// - By default the sleep pin requests sleep when it goes low.
// - Pin assignments are held per resource, split into general, switcher and linear groups.
// - Resources tied to one direct control pin and no other pin change mode together.
// - Resources tied only to the sleep pin change mode in stored sequence order.
// - A resource tied to no pin stays active whatever the pins do.
// - Stored sequences switch the regulators, the slow clock and the enable outputs.
// - Each sequence step is followed by its own stored delay.
// - A resource touched by no sequence keeps its enable unchanged while sequences run.
// - After the power-up sequence software may enable resources outside any sequence.
// - A sleep request starts the sleep sequence only when sleep is unmasked and no interrupt is pending.
// - A direct control pin change acts at once, bypassing the sequencer.
`timescale 1ns/10ps
`include "sr_cfg.svh"
module sr_resource_ctl import sr_pkg::*; #(
  parameter int N_RES = 4,
  parameter int N_SMPS = 5,
  parameter int N_LDO = 5,
  parameter int MEM_DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sleep_request_pin,
  input wire logic direct_mode_ctl_a,
  input wire logic direct_mode_ctl_b,
  input wire logic irq_pending,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [N_RES+N_SMPS+N_LDO-1:0] res_enable,
  output logic [N_RES+N_SMPS+N_LDO-1:0] res_active,
  output logic seq_busy,
  output logic dev_sleeping
);

  localparam int NR = N_RES + N_SMPS + N_LDO;
  localparam int MAW = $clog2(MEM_DEPTH);
  localparam int TW = $clog2(`SR_STEP_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(`SR_STEP_CYCLES - 1);

  // Pin synchronisers
  sr_pins_t pin_s1_ff, pin_s2_ff;
  sr_pins_t pins_raw;
  assign pins_raw = '{sleep: sleep_request_pin, ctl_a: direct_mode_ctl_a,
                      ctl_b: direct_mode_ctl_b};

  // Two flops before any logic reads a pin
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_s1_ff <= '{sleep: 1'b1, ctl_a: 1'b0, ctl_b: 1'b0};
      pin_s2_ff <= '{sleep: 1'b1, ctl_a: 1'b0, ctl_b: 1'b0};
    end else begin
      pin_s1_ff <= pins_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Configuration registers
  logic slp_unmask_ff, nxt_slp_unmask;
  logic [2:0] pol_ff, nxt_pol;
  logic [N_RES-1:0] slp_res_ff, a_res_ff, b_res_ff;
  logic [N_RES-1:0] nxt_slp_res, nxt_a_res, nxt_b_res;
  logic [N_SMPS-1:0] slp_smps_ff, a_smps_ff, b_smps_ff;
  logic [N_SMPS-1:0] nxt_slp_smps, nxt_a_smps, nxt_b_smps;
  logic [N_LDO-1:0] slp_ldo_ff, a_ldo_ff, b_ldo_ff;
  logic [N_LDO-1:0] nxt_slp_ldo, nxt_a_ldo, nxt_b_ldo;
  logic [14:0] seq_base_ff, nxt_seq_base;
  logic start_req;
  logic sw_en_wr;
  logic mem_wr;

  // Write decode for the configuration group
  always_comb begin
    nxt_slp_unmask = slp_unmask_ff;
    nxt_pol = pol_ff;
    nxt_slp_res = slp_res_ff;
    nxt_slp_smps = slp_smps_ff;
    nxt_slp_ldo = slp_ldo_ff;
    nxt_a_res = a_res_ff;
    nxt_a_smps = a_smps_ff;
    nxt_a_ldo = a_ldo_ff;
    nxt_b_res = b_res_ff;
    nxt_b_smps = b_smps_ff;
    nxt_b_ldo = b_ldo_ff;
    nxt_seq_base = seq_base_ff;
    start_req = 1'b0;
    sw_en_wr = 1'b0;
    mem_wr = 1'b0;
    if (!reg_wr) begin
      mem_wr = 1'b0;
    end else if (reg_addr[`SR_MEM_SEL_BIT]) begin
      mem_wr = 1'b1;
    end else if (reg_addr == `SR_OFS_CTRL) begin
      start_req = reg_wdata[`SR_CTRL_START_BIT];
      nxt_slp_unmask = reg_wdata[`SR_CTRL_SLP_UNMASK_BIT];
    end else if (reg_addr == `SR_OFS_POL) begin
      nxt_pol = reg_wdata[2:0];
    end else if (reg_addr == `SR_OFS_SLP_RES) begin
      nxt_slp_res = reg_wdata[N_RES-1:0];
    end else if (reg_addr == `SR_OFS_SLP_SMPS) begin
      nxt_slp_smps = reg_wdata[N_SMPS-1:0];
    end else if (reg_addr == `SR_OFS_SLP_LDO) begin
      nxt_slp_ldo = reg_wdata[N_LDO-1:0];
    end else if (reg_addr == `SR_OFS_A_RES) begin
      nxt_a_res = reg_wdata[N_RES-1:0];
    end else if (reg_addr == `SR_OFS_A_SMPS) begin
      nxt_a_smps = reg_wdata[N_SMPS-1:0];
    end else if (reg_addr == `SR_OFS_A_LDO) begin
      nxt_a_ldo = reg_wdata[N_LDO-1:0];
    end else if (reg_addr == `SR_OFS_B_RES) begin
      nxt_b_res = reg_wdata[N_RES-1:0];
    end else if (reg_addr == `SR_OFS_B_SMPS) begin
      nxt_b_smps = reg_wdata[N_SMPS-1:0];
    end else if (reg_addr == `SR_OFS_B_LDO) begin
      nxt_b_ldo = reg_wdata[N_LDO-1:0];
    end else if (reg_addr == `SR_OFS_SEQ_BASE) begin
      nxt_seq_base = reg_wdata[14:0];
    end else if (reg_addr == `SR_OFS_SW_EN) begin
      sw_en_wr = 1'b1;
    end
  end

  // Configuration flops
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      slp_unmask_ff <= 1'b0;
      pol_ff <= `SR_POL_RST;
      slp_res_ff <= '0;
      slp_smps_ff <= '0;
      slp_ldo_ff <= '0;
      a_res_ff <= '0;
      a_smps_ff <= '0;
      a_ldo_ff <= '0;
      b_res_ff <= '0;
      b_smps_ff <= '0;
      b_ldo_ff <= '0;
      seq_base_ff <= `SR_SEQ_BASE_RST;
    end else begin
      slp_unmask_ff <= nxt_slp_unmask;
      pol_ff <= nxt_pol;
      slp_res_ff <= nxt_slp_res;
      slp_smps_ff <= nxt_slp_smps;
      slp_ldo_ff <= nxt_slp_ldo;
      a_res_ff <= nxt_a_res;
      a_smps_ff <= nxt_a_smps;
      a_ldo_ff <= nxt_a_ldo;
      b_res_ff <= nxt_b_res;
      b_smps_ff <= nxt_b_smps;
      b_ldo_ff <= nxt_b_ldo;
      seq_base_ff <= nxt_seq_base;
    end
  end

  // Pin requests after polarity; pol bit 0 keeps the default sense
  logic sleep_req, act_a, act_b;
  assign sleep_req = pin_s2_ff.sleep ^ ~pol_ff[`SR_POL_SLEEP_BIT];
  assign act_a = pin_s2_ff.ctl_a ^ pol_ff[`SR_POL_A_BIT];
  assign act_b = pin_s2_ff.ctl_b ^ pol_ff[`SR_POL_B_BIT];

  logic [NR-1:0] slp_asg, a_asg, b_asg;
  assign slp_asg = {slp_ldo_ff, slp_smps_ff, slp_res_ff};
  assign a_asg = {a_ldo_ff, a_smps_ff, a_res_ff};
  assign b_asg = {b_ldo_ff, b_smps_ff, b_res_ff};

  // Step delay tick divider
  logic [TW-1:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick_ff, nxt_tick;

  always_comb begin
    nxt_tick = (tick_cnt_ff == TICK_LAST);
    nxt_tick_cnt = nxt_tick ? '0 : tick_cnt_ff + TW'(1);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff <= nxt_tick;
    end
  end

  // Sequence step memory
  logic [MAW-1:0] step_addr_ff, nxt_step_addr;
  logic [15:0] mem_rdata;
  sr_step_t step;
  assign step = sr_step_t'(mem_rdata);

  sr_step_mem #(.DEPTH(MEM_DEPTH), .AW(MAW), .DW(16)) u_mem (
    .ref_clk(ref_clk),
    .wr_en(mem_wr),
    .wr_addr(reg_addr[MAW-1:0]),
    .wr_data(reg_wdata),
    .rd_addr(step_addr_ff),
    .rd_data(mem_rdata)
  );

  // Sequence engine state
  sr_state_t state_ff, nxt_state;
  sr_seq_kind_t kind_ff, nxt_kind;
  logic [7:0] dly_ff, nxt_dly;
  logic last_ff, nxt_last;
  logic [NR-1:0] en_ff, nxt_en;
  logic [NR-1:0] in_seq_ff, nxt_in_seq;
  logic [NR-1:0] seq_mode_ff, nxt_seq_mode;
  logic [NR-1:0] step_hot;
  assign step_hot = NR'(1) << step.res;

  // Engine next state
  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_dly = dly_ff;
    nxt_last = last_ff;
    nxt_en = en_ff;
    nxt_in_seq = in_seq_ff;
    nxt_seq_mode = seq_mode_ff;
    nxt_step_addr = step_addr_ff;
    case (state_ff)
      SR_ST_OFF: begin
        if (start_req) begin
          nxt_kind = SR_SEQ_UP;
          nxt_step_addr = seq_base_ff[MAW-1:0];
          nxt_state = SR_ST_FETCH;
        end
      end
      SR_ST_FETCH: begin
        nxt_state = SR_ST_EXEC; // Memory data ready next cycle
      end
      SR_ST_EXEC: begin
        if (kind_ff == SR_SEQ_UP) begin
          nxt_en = step.on ? (en_ff | step_hot) : (en_ff & ~step_hot);
          nxt_in_seq = in_seq_ff | step_hot;
        end else begin
          nxt_seq_mode = step.on ? (seq_mode_ff | step_hot)
                                 : (seq_mode_ff & ~step_hot);
        end
        nxt_dly = step.delay;
        nxt_last = step.last;
        nxt_state = SR_ST_WAIT;
      end
      SR_ST_WAIT: begin
        if (dly_ff == 8'h00) begin
          if (!last_ff) begin
            nxt_step_addr = step_addr_ff + MAW'(1);
            nxt_state = SR_ST_FETCH;
          end else if (kind_ff == SR_SEQ_A2S) begin
            nxt_state = SR_ST_SLEEP;
          end else begin
            nxt_state = SR_ST_ACTIVE;
          end
        end else if (tick_ff) begin
          nxt_dly = dly_ff - 8'h01;
        end
      end
      SR_ST_ACTIVE: begin
        if (sw_en_wr) begin
          nxt_en = (en_ff & in_seq_ff) | (reg_wdata[NR-1:0] & ~in_seq_ff);
        end
        if (sleep_req && slp_unmask_ff && !irq_pending) begin
          nxt_kind = SR_SEQ_A2S;
          nxt_step_addr = seq_base_ff[5+MAW-1:5];
          nxt_state = SR_ST_FETCH;
        end
      end
      SR_ST_SLEEP: begin
        if (sw_en_wr) begin
          nxt_en = (en_ff & in_seq_ff) | (reg_wdata[NR-1:0] & ~in_seq_ff);
        end
        if (!sleep_req || irq_pending) begin
          nxt_kind = SR_SEQ_S2A;
          nxt_step_addr = seq_base_ff[10+MAW-1:10];
          nxt_state = SR_ST_FETCH;
        end
      end
      default: begin
        nxt_state = SR_ST_OFF;
      end
    endcase
  end

  // Engine flops
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_ff <= SR_ST_OFF;
      kind_ff <= SR_SEQ_UP;
      dly_ff <= 8'h00;
      last_ff <= 1'b0;
      en_ff <= '0;
      in_seq_ff <= '0;
      seq_mode_ff <= '1;
      step_addr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      dly_ff <= nxt_dly;
      last_ff <= nxt_last;
      en_ff <= nxt_en;
      in_seq_ff <= nxt_in_seq;
      seq_mode_ff <= nxt_seq_mode;
      step_addr_ff <= nxt_step_addr;
    end
  end

  // Per resource mode: any tied pin asking active wins
  logic [NR-1:0] mode_act;
  // One driver per bit, so the bits never share a process
  for (genvar i = 0; i < NR; i++) begin : g_mode
    assign mode_act[i] = !(slp_asg[i] | a_asg[i] | b_asg[i]) ? 1'b1
                         : ((a_asg[i] & act_a) | (b_asg[i] & act_b)
                            | (slp_asg[i] & seq_mode_ff[i]));
  end

  // Register read mux
  logic [15:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 16'h0000;
    if (!reg_rd || reg_addr[`SR_MEM_SEL_BIT]) begin
      nxt_rdata = 16'h0000;
    end else if (reg_addr == `SR_OFS_CTRL) begin
      nxt_rdata = {14'h0000, slp_unmask_ff, 1'b0};
    end else if (reg_addr == `SR_OFS_POL) begin
      nxt_rdata = {13'h0000, pol_ff};
    end else if (reg_addr == `SR_OFS_SLP_RES) begin
      nxt_rdata = 16'(slp_res_ff);
    end else if (reg_addr == `SR_OFS_SLP_SMPS) begin
      nxt_rdata = 16'(slp_smps_ff);
    end else if (reg_addr == `SR_OFS_SLP_LDO) begin
      nxt_rdata = 16'(slp_ldo_ff);
    end else if (reg_addr == `SR_OFS_A_RES) begin
      nxt_rdata = 16'(a_res_ff);
    end else if (reg_addr == `SR_OFS_A_SMPS) begin
      nxt_rdata = 16'(a_smps_ff);
    end else if (reg_addr == `SR_OFS_A_LDO) begin
      nxt_rdata = 16'(a_ldo_ff);
    end else if (reg_addr == `SR_OFS_B_RES) begin
      nxt_rdata = 16'(b_res_ff);
    end else if (reg_addr == `SR_OFS_B_SMPS) begin
      nxt_rdata = 16'(b_smps_ff);
    end else if (reg_addr == `SR_OFS_B_LDO) begin
      nxt_rdata = 16'(b_ldo_ff);
    end else if (reg_addr == `SR_OFS_SEQ_BASE) begin
      nxt_rdata = {1'b0, seq_base_ff};
    end else if (reg_addr == `SR_OFS_SW_EN) begin
      nxt_rdata = 16'(en_ff);
    end else if (reg_addr == `SR_OFS_STATUS) begin
      nxt_rdata = {11'h000, kind_ff, state_ff};
    end else if (reg_addr == `SR_OFS_ACTIVE) begin
      nxt_rdata = 16'(res_active);
    end else if (reg_addr == `SR_OFS_IN_SEQ) begin
      nxt_rdata = 16'(in_seq_ff);
    end
  end

  // Output status next values
  logic nxt_busy, nxt_sleeping;
  always_comb begin
    nxt_busy = (state_ff == SR_ST_FETCH) || (state_ff == SR_ST_EXEC)
               || (state_ff == SR_ST_WAIT);
    nxt_sleeping = (state_ff == SR_ST_SLEEP);
  end

  // Output flops
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
      res_enable <= '0;
      res_active <= '1;
      seq_busy <= 1'b0;
      dev_sleeping <= 1'b0;
    end else begin
      reg_rdata <= nxt_rdata;
      res_enable <= en_ff;
      res_active <= mode_act;
      seq_busy <= nxt_busy;
      dev_sleeping <= nxt_sleeping;
    end
  end

endmodule

// file: testbench/sr_ctl_asserts.sv
// Port checker for the sleep/active resource controller.
// Assumes default sizes, general resources in the low four bits.
`timescale 1ns/10ps
`include "sr_cfg.svh"
module sr_ctl_asserts import sr_pkg::*; #(
  parameter int N_RES = 4,
  parameter int N_SMPS = 5,
  parameter int N_LDO = 5,
  parameter int MEM_DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sleep_request_pin,
  input wire logic direct_mode_ctl_a,
  input wire logic direct_mode_ctl_b,
  input wire logic irq_pending,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [N_RES+N_SMPS+N_LDO-1:0] res_enable,
  input wire logic [N_RES+N_SMPS+N_LDO-1:0] res_active,
  input wire logic seq_busy,
  input wire logic dev_sleeping
);
  logic [3:0] sa_ff, sb_ff, ss_ff, nxt_sa, nxt_sb, nxt_ss, want;
  logic [2:0] pol_ff, nxt_pol;
  logic act_a, act_b;

  // Shadow of general assignments and pin polarity
  always_comb begin
    nxt_sa = sa_ff;
    nxt_sb = sb_ff;
    nxt_ss = ss_ff;
    nxt_pol = pol_ff;
    if (reg_wr && reg_addr == `SR_OFS_A_RES) nxt_sa = reg_wdata[3:0];
    if (reg_wr && reg_addr == `SR_OFS_B_RES) nxt_sb = reg_wdata[3:0];
    if (reg_wr && reg_addr == `SR_OFS_SLP_RES) nxt_ss = reg_wdata[3:0];
    if (reg_wr && reg_addr == `SR_OFS_POL) nxt_pol = reg_wdata[2:0];
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sa_ff <= 4'h0;
      sb_ff <= 4'h0;
      ss_ff <= 4'h0;
      pol_ff <= 3'h0;
    end else begin
      sa_ff <= nxt_sa;
      sb_ff <= nxt_sb;
      ss_ff <= nxt_ss;
      pol_ff <= nxt_pol;
    end
  end

  // Mode the direct pins alone should give
  assign act_a = direct_mode_ctl_a ^ pol_ff[1];
  assign act_b = direct_mode_ctl_b ^ pol_ff[2];
  assign want = (sa_ff & {4{act_a}}) | (sb_ff & {4{act_b}}) | ~(sa_ff | sb_ff);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_RESET_OUTPUTS: assert property (
    disable iff (1'b0) !rstn |=> res_enable == '0 && (&res_active) && !seq_busy
      && !dev_sleeping && reg_rdata == 16'h0000)
    else $error("outputs not at reset values");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  AST_IRQ_BLOCKS_SLEEP: assert property (
    (irq_pending && !reg_wr && !seq_busy && !dev_sleeping)[*3] |=> !seq_busy)
    else $error("sequence started with interrupt pending");
  AST_QUIET_HOLDS: assert property (
    (!reg_wr && !seq_busy && $stable({sleep_request_pin, direct_mode_ctl_a,
      direct_mode_ctl_b, irq_pending}))[*6] |=> $stable(res_active) && $stable(res_enable))
    else $error("resource changed with no cause");
  AST_DIRECT_MODE: assert property (
    (!reg_wr && $stable(direct_mode_ctl_a) && $stable(direct_mode_ctl_b))[*4]
      |-> (res_active[3:0] & ~ss_ff) == (want & ~ss_ff))
    else $error("direct pin mode mismatch");
  AST_SLEEP_NOT_BUSY: assert property (dev_sleeping |-> !seq_busy)
    else $error("sleeping while sequence busy");
  AST_SLEEP_AFTER_SEQ: assert property (
    $rose(dev_sleeping) |-> $past(seq_busy) || $past(seq_busy, 2))
    else $error("sleep entered without a sequence");
  AST_ENABLE_CAUSE: assert property (
    $changed(res_enable) |-> $past(seq_busy) || $past(seq_busy, 2) || $past(reg_wr)
      || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("enable changed outside sequence or write");

  // Main scenarios reached
  cover property ($rose(dev_sleeping));
  cover property ($fell(dev_sleeping));
  cover property ($rose(seq_busy));
endmodule

bind sr_resource_ctl sr_ctl_asserts #(.N_RES(N_RES), .N_SMPS(N_SMPS), .N_LDO(N_LDO),
  .MEM_DEPTH(MEM_DEPTH)) chk_u (.*);

// file: testbench/sr_host_pins.sv
// Host model driving the sleep, direct mode and interrupt lines.
// Assumes calls are made right after a rising clock edge.
`timescale 1ns/10ps
module sr_host_pins (
  input wire logic ref_clk,
  output logic sleep_request_pin,
  output logic direct_mode_ctl_a,
  output logic direct_mode_ctl_b,
  output logic irq_pending
);
  // Idle levels: no sleep request, nothing pending
  initial begin
    sleep_request_pin = 1'b1;
    direct_mode_ctl_a = 1'b0;
    direct_mode_ctl_b = 1'b0;
    irq_pending = 1'b0;
  end

  // New levels just after the next edge
  task automatic drive(input logic s, input logic a, input logic b, input logic i);
    @(posedge ref_clk);
    sleep_request_pin <= s;
    direct_mode_ctl_a <= a;
    direct_mode_ctl_b <= b;
    irq_pending <= i;
  endtask
endmodule

// file: testbench/sleep_active_resource_control_tb.sv
// Self-checking bench for the sleep/active resource controller.
// Assumes the bound checker and the host pin model.
`timescale 1ns/10ps
`include "sr_cfg.svh"
module sleep_active_resource_control_tb import sr_pkg::*;;
  logic ref_clk, rstn, reg_wr, reg_rd, seq_busy, dev_sleeping;
  logic [5:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [13:0] res_enable, res_active;
  wire sleep_request_pin, direct_mode_ctl_a, direct_mode_ctl_b, irq_pending;
  int errors, checks_done;
  logic [21:0] cfg [11];
  logic [18:0] rows [7];

  sr_host_pins host_u (.*);
  sr_resource_ctl dut_u (.*);

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    @(posedge ref_clk);
  endtask

  task automatic give_verdict();
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Waits for a running sequence to end, bounded
  task automatic settle(input int lim);
    int n;
    n = 0;
    repeat (6) @(posedge ref_clk);
    while (seq_busy !== 1'b0 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= lim) begin
      errors++;
      $display("[ERR] %0t sequence did not finish", $time);
      give_verdict();
    end
  endtask

  task automatic chk_reset();
    chk({2'h0, res_enable}, 16'h0000);
    chk({2'h0, res_active}, 16'h3FFF);
    chk({14'h0, seq_busy, dev_sleeping}, 16'h0000);
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
    errors = 0;
    checks_done = 0;
    cfg = '{{`SR_OFS_A_RES, 16'h0003}, {`SR_OFS_A_SMPS, 16'h0001},
      {`SR_OFS_B_RES, 16'h0002}, {`SR_OFS_B_LDO, 16'h0001}, {`SR_OFS_SLP_RES, 16'h000C},
      {`SR_OFS_SEQ_BASE, 16'h2080}, {6'h20, 16'h4001}, {6'h21, 16'hC500},
      {6'h24, 16'h0202}, {6'h25, 16'h8300}, {6'h28, 16'h4300}};
    rows = '{{3'b000, 2'b00, 14'h3DEC}, {3'b000, 2'b10, 14'h3DFF},
      {3'b000, 2'b01, 14'h3FEE}, {3'b000, 2'b11, 14'h3FFF}, {3'b010, 2'b00, 14'h3DFF},
      {3'b110, 2'b00, 14'h3FFF}, {3'b100, 2'b11, 14'h3DFF}};
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    chk_reset();
    rd_chk(`SR_OFS_POL, 16'h0000);
    wr(6'h10, 16'hFFFF);
    rd_chk(6'h10, 16'h0000);
    wr(`SR_OFS_SW_EN, 16'h0080);
    foreach (cfg[i]) wr(cfg[i][21:16], cfg[i][15:0]);
    wr(6'h29, 16'hC200);
    rd_chk(`SR_OFS_A_SMPS, 16'h0001);
    chk({2'h0, res_enable}, 16'h0000);
    wr(`SR_OFS_CTRL, 16'h0001);
    repeat (20) @(posedge ref_clk);
    chk({2'h0, res_enable}, 16'h0001);
    settle(1000);
    chk({2'h0, res_enable}, 16'h0021);
    rd_chk(`SR_OFS_IN_SEQ, 16'h0021);
    wr(`SR_OFS_SW_EN, 16'h0040);
    repeat (3) @(posedge ref_clk);
    chk({2'h0, res_enable}, 16'h0061);
    // Direct pin cases from the table
    foreach (rows[i]) begin
      wr(`SR_OFS_POL, {13'h0, rows[i][18:16]});
      host_u.drive(1'b1, rows[i][15], rows[i][14], 1'b0);
      repeat (5) @(posedge ref_clk);
      chk({2'h0, res_active}, {2'h0, rows[i][13:0]});
    end
    // Sleep held off by a pending interrupt, then sequenced
    wr(`SR_OFS_POL, 16'h0000);
    wr(`SR_OFS_CTRL, 16'h0002);
    host_u.drive(1'b0, 1'b1, 1'b1, 1'b1);
    repeat (20) @(posedge ref_clk);
    chk({14'h0, seq_busy, dev_sleeping}, 16'h0000);
    host_u.drive(1'b0, 1'b1, 1'b1, 1'b0);
    repeat (12) @(posedge ref_clk);
    chk({2'h0, res_active}, 16'h3FFB);
    settle(1000);
    chk({2'h0, res_active}, 16'h3FF3);
    chk({14'h0, seq_busy, dev_sleeping}, 16'h0001);
    rd_chk(`SR_OFS_STATUS, 16'h000D);
    host_u.drive(1'b1, 1'b1, 1'b1, 1'b0);
    settle(1000);
    chk({2'h0, res_active}, 16'h3FFF);
    chk({14'h0, seq_busy, dev_sleeping}, 16'h0000);
    // Inverted sleep sense turns a high pin into a request
    wr(`SR_OFS_POL, 16'h0001);
    settle(1000);
    chk({14'h0, seq_busy, dev_sleeping}, 16'h0001);
    // Pending interrupt wakes, then holds off a new sleep
    host_u.drive(1'b1, 1'b1, 1'b1, 1'b1);
    settle(1000);
    chk({14'h0, seq_busy, dev_sleeping}, 16'h0000);
    chk({2'h0, res_active}, 16'h3FFF);
    // Reset in mid-run
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    chk_reset();
    give_verdict();
  end
endmodule
